//--- src/calib_dc_pkg.sv
// shared constants for the calibration, dc termination and line status registers
// assumes an 8-bit register port and a single 40 MHz clock

package calib_dc_pkg;

	// ----------------------------------------------------------------
	// bus widths
	// ----------------------------------------------------------------
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	localparam int TRIM_W = 4;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] CAL_OFS = 8'h19; // resistor_calibration
	localparam logic [ADDR_W-1:0] DC_OFS = 8'h1A; // dc_termination_control
	localparam logic [ADDR_W-1:0] RSVD_OFS = 8'h1B; // reserved_block
	localparam logic [ADDR_W-1:0] LC_OFS = 8'h1C; // loop_current_status
	localparam logic [ADDR_W-1:0] LV_OFS = 8'h1D; // line_voltage_status

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CAL_ACTIVE_BIT = 7;
	localparam int CAL_MANUAL_BIT = 6;
	localparam int CAL_DISABLE_BIT = 5;
	localparam int CAL_TRIM_LSB = 0;
	localparam int DC_VADJ_LSB = 6;
	localparam int DC_MINI_LSB = 4;
	localparam int DC_CURRENT_LIMIT_ENABLE_BIT = 1;
	localparam int DC_DCR_BIT = 0;
	localparam int LV_SIGN_BIT = 7;

	// ----------------------------------------------------------------
	// reset values and masks
	// ----------------------------------------------------------------
	localparam logic [DATA_W-1:0] CAL_RESET = 8'h00;
	localparam logic [DATA_W-1:0] DC_RESET = 8'h00;
	localparam logic [DATA_W-1:0] LC_RESET = 8'h00;
	localparam logic [DATA_W-1:0] LV_RESET = 8'h00;
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
	// bits of the dc register that hold state; reserved 3:2 read zero
	localparam logic [DATA_W-1:0] DC_KEEP_MASK = 8'hF3;

	// ----------------------------------------------------------------
	// fixed settings of reduced-feature variants, and the line voltage zero-force threshold
	// ----------------------------------------------------------------
	localparam logic [1:0] FIXED_VADJ_CODE = 2'h2; // 3.35 V
	localparam logic [1:0] FIXED_MINI_CODE = 2'h0; // 10 mA
	// line voltage magnitude at or below which status is forced to zero
	localparam logic [DATA_W-1:0] LV_FORCE_ZERO_V = 8'h03;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 40;
	localparam int CAL_RUN_US = 10; // length of one calibration run
	localparam int CAL_RUN_CYCLES = CAL_RUN_US * CLK_MHZ;
	localparam int CAL_CNT_W = 16;

	// ----------------------------------------------------------------
	// calibration sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CAL_IDLE = 3'b001,
		CAL_RUN = 3'b010,
		CAL_LATCH = 3'b100
	} cal_state_t;

	// termination pin voltage in millivolts per adjust code
	function automatic logic [11:0] vadj_to_mv(input logic [1:0] code);
		case (code)
			2'h0: vadj_to_mv = 12'd3100;
			2'h1: vadj_to_mv = 12'd3200;
			2'h2: vadj_to_mv = 12'd3350;
			default: vadj_to_mv = 12'd3500;
		endcase
	endfunction : vadj_to_mv

	// minimum loop current in milliamps per select code
	function automatic logic [4:0] mini_to_ma(input logic [1:0] code);
		case (code)
			2'h0: mini_to_ma = 5'd10;
			2'h1: mini_to_ma = 5'd12;
			2'h2: mini_to_ma = 5'd14;
			default: mini_to_ma = 5'd16;
		endcase
	endfunction : mini_to_ma

endpackage : calib_dc_pkg

//--- src/calib_if.sv
// request and result signals between the register bank and the calibration sequencer
// assumes both ends share mclk

`timescale 1ns/10ps

interface calib_if;
	logic manualStart; // one-cycle pulse, manual run requested
	logic autoRequest; // one-cycle pulse, internal run requested
	logic calDisable; // level, internal runs blocked
	logic busy; // level, a run is in progress
	logic done; // one-cycle pulse, run finished
	logic [calib_dc_pkg::TRIM_W-1:0] trim; // measured trim, valid while done is high

	// ----------------------------------------------------------------
	// ends
	// ----------------------------------------------------------------
	modport seq (input manualStart, input autoRequest, input calDisable,
		output busy, output done, output trim);
	modport regs (output manualStart, output autoRequest, output calDisable,
		input busy, input done, input trim);
endinterface : calib_if

//--- src/calib_sequencer.sv
// resistor calibration sequencer: runs a timed calibration and flags when its trim is ready
// assumes the analog trim result is stable when the run ends

`timescale 1ns/10ps

module calib_sequencer #(
	parameter logic [calib_dc_pkg::CAL_CNT_W-1:0] RUN_CYCLES =
		calib_dc_pkg::CAL_CNT_W'(calib_dc_pkg::CAL_RUN_CYCLES)
) (
	input wire logic mclk,
	input wire logic rst,
	calib_if.seq cal,
	input wire logic [calib_dc_pkg::TRIM_W-1:0] trimMeasured,
	output logic calibRun
);
	import calib_dc_pkg::*;

	cal_state_t state_reg; // sequencer state
	logic [CAL_CNT_W-1:0] count_reg; // cycles left in the run
	logic startReq; // qualified request this cycle

	// ----------------------------------------------------------------
	// request qualification
	// ----------------------------------------------------------------
	// internal runs gated
	assign startReq = cal.manualStart | (cal.autoRequest & ~cal.calDisable);

	// state walk; requests during a run are dropped, not queued
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			state_reg <= CAL_IDLE;
		else
		begin
			case (state_reg)
				CAL_IDLE: if (startReq) state_reg <= CAL_RUN;
				CAL_RUN: if (count_reg == '0) state_reg <= CAL_LATCH;
				CAL_LATCH: state_reg <= CAL_IDLE;
				default: state_reg <= CAL_IDLE;
			endcase
		end
	end

	// run timer, loaded on start
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			count_reg <= '0;
		else if (state_reg == CAL_IDLE && startReq)
			count_reg <= RUN_CYCLES - CAL_CNT_W'(1);
		else if (state_reg == CAL_RUN && count_reg != '0)
			count_reg <= count_reg - CAL_CNT_W'(1);
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// busy while running and in the latch cycle
	assign cal.busy = (state_reg == CAL_RUN) || (state_reg == CAL_LATCH);
	assign cal.done = (state_reg == CAL_LATCH);
	assign cal.trim = trimMeasured; // the bank latches it while done is high
	assign calibRun = (state_reg == CAL_RUN);
endmodule : calib_sequencer

//--- src/line_side_calib_dc_status_regs.sv
// register bank for resistor calibration, dc termination and line status
// assumes a single-cycle register port and measurement samples on mclk

`timescale 1ns/10ps

module line_side_calib_dc_status_regs #(
	parameter bit FULL_FEATURE = 1'b1, // adjust and minimum-current fields honoured
	parameter bit LIMIT_SUPPORTED = 1'b1, // current limiting available
	parameter logic [calib_dc_pkg::CAL_CNT_W-1:0] CAL_RUN_CYCLES =
		calib_dc_pkg::CAL_CNT_W'(calib_dc_pkg::CAL_RUN_CYCLES)
) (
	input wire logic mclk,
	input wire logic rst,
	// register port
	input wire logic [calib_dc_pkg::ADDR_W-1:0] regAddr,
	input wire logic [calib_dc_pkg::DATA_W-1:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [calib_dc_pkg::DATA_W-1:0] regRdData,
	// calibration analog side
	input wire logic autoCalRequest,
	input wire logic [calib_dc_pkg::TRIM_W-1:0] trimMeasured,
	output logic calibRun,
	// measurement side
	input wire logic sampleValid,
	input wire logic [calib_dc_pkg::DATA_W-1:0] loopCurrentSample,
	input wire logic [calib_dc_pkg::DATA_W-1:0] lineVoltageSample,
	input wire logic zeroForceDisable,
	// termination controls
	output logic [1:0] lineVoltageAdjust,
	output logic [11:0] terminationPinMv,
	output logic [1:0] minLoopCurrentSel,
	output logic [4:0] minLoopCurrentMa,
	output logic currentLimitEnable,
	output logic dcImpedanceSelect,
	output logic polarityReversal
);
	import calib_dc_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	calib_if calBus(); // link to the sequencer

	logic manualTrig_reg; // stored manual request bit
	logic calDisable_reg; // stored disable bit
	logic [TRIM_W-1:0] trim_reg; // calibration trim value field
	logic [DATA_W-1:0] dc_reg; // dc termination settings
	logic [DATA_W-1:0] loopCurrent_reg; // loop current status
	logic [DATA_W-1:0] lineVoltage_reg; // line voltage status
	logic lastPolarity_reg; // sign of the last nonzero voltage
	logic polarityKnown_reg; // a nonzero voltage has been seen
	logic polarityPulse_reg; // registered reversal pulse
	logic [DATA_W-1:0] rdData_reg; // read data, one cycle after the strobe
	logic [DATA_W-1:0] rdData_next; // read mux

	logic wrCal; // write to calibration register
	logic wrDc; // write to dc register
	logic [DATA_W-1:0] voltMag; // magnitude of the voltage sample
	logic forceZero; // voltage sample to be reported as zero
	logic [DATA_W-1:0] lineVoltage_next; // voltage after the zero force
	logic [1:0] vadjEff; // effective adjust code
	logic [1:0] miniEff; // effective minimum-current code
	// reset codes follow the reset register, or the fixed codes in reduced variants, so no step appears after reset
	localparam logic [1:0] VADJ_RESET = FULL_FEATURE ? DC_RESET[DC_VADJ_LSB +: 2] : FIXED_VADJ_CODE;
	localparam logic [1:0] MINI_RESET = FULL_FEATURE ? DC_RESET[DC_MINI_LSB +: 2] : FIXED_MINI_CODE;

	// ----------------------------------------------------------------
	// write decode
	// ----------------------------------------------------------------
	always_comb
	begin
		wrCal = 1'b0;
		wrDc = 1'b0;
		if (regWrite && regAddr == CAL_OFS)
			wrCal = 1'b1;
		else if (regWrite && regAddr == DC_OFS)
			wrDc = 1'b1;
		else if (regWrite && regAddr == RSVD_OFS)
			wrDc = 1'b0;
	end

	// ----------------------------------------------------------------
	// calibration register
	// ----------------------------------------------------------------
	// manual request bit, plain storage
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			manualTrig_reg <= CAL_RESET[CAL_MANUAL_BIT];
		else if (wrCal)
			manualTrig_reg <= regWrData[CAL_MANUAL_BIT];
	end

	// disable bit, plain storage
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			calDisable_reg <= CAL_RESET[CAL_DISABLE_BIT];
		else if (wrCal)
			calDisable_reg <= regWrData[CAL_DISABLE_BIT];
	end

	// trim field; the end of a run wins over a write in the same cycle
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			trim_reg <= CAL_RESET[CAL_TRIM_LSB +: TRIM_W];
		else if (calBus.done)
			trim_reg <= calBus.trim;
		else if (wrCal)
			trim_reg <= regWrData[CAL_TRIM_LSB +: TRIM_W];
	end

	// ----------------------------------------------------------------
	// calibration requests
	// ----------------------------------------------------------------
	// rising write starts run; held bit never retriggers
	assign calBus.manualStart = wrCal & regWrData[CAL_MANUAL_BIT] & ~manualTrig_reg;
	// internal request from the analog side
	assign calBus.autoRequest = autoCalRequest;
	assign calBus.calDisable = calDisable_reg;

	// timed run and trim capture
	calib_sequencer #(
		.RUN_CYCLES(CAL_RUN_CYCLES)
	) sequencer (
		.mclk(mclk),
		.rst(rst),
		.cal(calBus),
		.trimMeasured(trimMeasured),
		.calibRun(calibRun)
	);

	// ----------------------------------------------------------------
	// dc termination register
	// ----------------------------------------------------------------
	// reserved bits are not stored, so stray writes cannot show up
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			dc_reg <= DC_RESET;
		else if (wrDc)
			dc_reg <= regWrData & DC_KEEP_MASK;
	end

	// reduced variants ignore the fields rather than rejecting the write
	always_comb
	begin
		vadjEff = FIXED_VADJ_CODE;
		miniEff = FIXED_MINI_CODE;
		if (FULL_FEATURE)
		begin
			vadjEff = dc_reg[DC_VADJ_LSB +: 2];
			miniEff = dc_reg[DC_MINI_LSB +: 2];
		end
	end

	// termination outputs, registered for glitch-free analog controls
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			lineVoltageAdjust <= VADJ_RESET;
			terminationPinMv <= vadj_to_mv(VADJ_RESET);
			minLoopCurrentSel <= MINI_RESET;
			minLoopCurrentMa <= mini_to_ma(MINI_RESET);
			currentLimitEnable <= 1'b0;
			dcImpedanceSelect <= 1'b0;
		end
		else
		begin
			lineVoltageAdjust <= vadjEff;
			terminationPinMv <= vadj_to_mv(vadjEff);
			minLoopCurrentSel <= miniEff;
			minLoopCurrentMa <= mini_to_ma(miniEff);
			currentLimitEnable <= LIMIT_SUPPORTED & dc_reg[DC_CURRENT_LIMIT_ENABLE_BIT];
			dcImpedanceSelect <= dc_reg[DC_DCR_BIT];
		end
	end

	// ----------------------------------------------------------------
	// loop current status
	// ----------------------------------------------------------------
	// zero from the converter already means below operating current
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			loopCurrent_reg <= LC_RESET;
		else if (sampleValid)
			loopCurrent_reg <= loopCurrentSample;
	end

	// ----------------------------------------------------------------
	// line voltage status
	// ----------------------------------------------------------------
	// magnitude of a two's-complement sample; -128 maps to 0x80
	assign voltMag = lineVoltageSample[LV_SIGN_BIT] ?
		DATA_W'(~lineVoltageSample + DATA_W'(1)) : lineVoltageSample;

	assign forceZero = ~zeroForceDisable && voltMag <= LV_FORCE_ZERO_V;
	assign lineVoltage_next = forceZero ? ZERO_BYTE : lineVoltageSample;

	// hook state is not looked at, so updates continue in both states
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			lineVoltage_reg <= LV_RESET;
		else if (sampleValid)
			lineVoltage_reg <= lineVoltage_next;
	end

	// polarity tracking ignores zero readings, which carry no sign
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			lastPolarity_reg <= 1'b0;
			polarityKnown_reg <= 1'b0;
		end
		else if (sampleValid && lineVoltage_next != ZERO_BYTE)
		begin
			lastPolarity_reg <= lineVoltage_next[LV_SIGN_BIT];
			polarityKnown_reg <= 1'b1;
		end
	end

	// one-cycle pulse when a new nonzero sample flips sign
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			polarityPulse_reg <= 1'b0;
		else
			polarityPulse_reg <= sampleValid && polarityKnown_reg &&
				lineVoltage_next != ZERO_BYTE &&
				lineVoltage_next[LV_SIGN_BIT] != lastPolarity_reg;
	end

	assign polarityReversal = polarityPulse_reg;

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	// reads only select data; no state changes on a read
	always_comb
	begin
		rdData_next = ZERO_BYTE;
		if (regAddr == CAL_OFS)
		begin
			rdData_next[CAL_ACTIVE_BIT] = calBus.busy;
			rdData_next[CAL_MANUAL_BIT] = manualTrig_reg;
			rdData_next[CAL_DISABLE_BIT] = calDisable_reg;
			rdData_next[CAL_TRIM_LSB +: TRIM_W] = trim_reg;
		end
		else if (regAddr == DC_OFS)
			rdData_next = dc_reg;
		else if (regAddr == LC_OFS)
			rdData_next = loopCurrent_reg;
		else if (regAddr == LV_OFS)
			rdData_next = lineVoltage_reg;
		// reserved and unmapped addresses read zero
		else
			rdData_next = ZERO_BYTE;
	end

	// data stands only in the cycle after the strobe
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			rdData_reg <= ZERO_BYTE;
		else if (regRead)
			rdData_reg <= rdData_next;
		else
			rdData_reg <= ZERO_BYTE;
	end

	assign regRdData = rdData_reg;
endmodule : line_side_calib_dc_status_regs

//--- tb/calib_dc_properties.sv
// concurrent checks on the calibration and dc termination register bank
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/10ps
module calib_dc_checker #(
	parameter logic [15:0] CAL_RUN_CYCLES = 16'h0190
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regRdData,
	input wire logic autoCalRequest,
	input wire logic calibRun,
	input wire logic sampleValid,
	input wire logic [1:0] lineVoltageAdjust,
	input wire logic [11:0] terminationPinMv,
	input wire logic [1:0] minLoopCurrentSel,
	input wire logic [4:0] minLoopCurrentMa,
	input wire logic currentLimitEnable,
	input wire logic dcImpedanceSelect,
	input wire logic polarityReversal
);
	import calib_dc_pkg::*;
	// ----------------------------------------------------------------
	// helper logic
	// ----------------------------------------------------------------
	logic [15:0] runCnt; // cycles the current run has lasted
	logic [11:0] expMv; // pin voltage the adjust code should give
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	// counts run length so the length check needs no long repetition
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			runCnt <= 16'h0000;
		else if (calibRun)
			runCnt <= runCnt + 16'h0001;
		else
			runCnt <= 16'h0000;
	end
	// independent voltage table, not the design's function
	always_comb
	begin
		case (lineVoltageAdjust)
			2'h0: expMv = 12'hC1C;
			2'h1: expMv = 12'hC80;
			2'h2: expMv = 12'hD16;
			default: expMv = 12'hDAC;
		endcase
	end
	sequence dcWrite;
		regWrite && regAddr == DC_OFS;
	endsequence
	sequence dcWriteThenRead;
		dcWrite ##2 (regRead && regAddr == DC_OFS);
	endsequence
	chk_read_idle: assert property (regRdData != 8'h00 |-> $past(regRead))
		else $error("read data shown without a read");
	chk_run_cause: assert property ($rose(calibRun) |->
		$past((regWrite && regAddr == CAL_OFS && regWrData[6]) || autoCalRequest))
		else $error("calibration started without a request");
	chk_run_length: assert property ($fell(calibRun) |-> runCnt == CAL_RUN_CYCLES)
		else $error("calibration run has wrong length");
	chk_pin_mv: assert property (terminationPinMv == expMv)
		else $error("pin voltage does not match adjust code");
	chk_min_ma: assert property (minLoopCurrentMa == 5'h0A + {2'h0, minLoopCurrentSel, 1'b0})
		else $error("minimum current does not match select code");
	chk_dc_fields: assert property (dcWrite |-> ##2
		lineVoltageAdjust == $past(regWrData[7:6], 2) && minLoopCurrentSel == $past(regWrData[5:4], 2))
		else $error("adjust or minimum current code not applied");
	chk_dc_switches: assert property (dcWrite |-> ##2
		{currentLimitEnable, dcImpedanceSelect} == $past(regWrData[1:0], 2))
		else $error("limit or impedance bit not applied");
	chk_dc_readback: assert property (dcWriteThenRead |=>
		regRdData == ($past(regWrData, 3) & 8'hF3))
		else $error("dc register readback wrong");
	chk_reversal_cause: assert property (polarityReversal |-> $past(sampleValid))
		else $error("polarity pulse without a sample");
endmodule : calib_dc_checker
bind line_side_calib_dc_status_regs calib_dc_checker #(.CAL_RUN_CYCLES(CAL_RUN_CYCLES)) chk_u (
	.mclk(mclk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
	.regRead(regRead), .regRdData(regRdData), .autoCalRequest(autoCalRequest),
	.calibRun(calibRun), .sampleValid(sampleValid), .lineVoltageAdjust(lineVoltageAdjust),
	.terminationPinMv(terminationPinMv), .minLoopCurrentSel(minLoopCurrentSel),
	.minLoopCurrentMa(minLoopCurrentMa), .currentLimitEnable(currentLimitEnable),
	.dcImpedanceSelect(dcImpedanceSelect), .polarityReversal(polarityReversal));

//--- tb/sys_side_master.sv
// system-side register master: issues single-cycle writes and reads
// assumes tasks are entered right after a rising edge of mclk
`timescale 1ns/10ps
module sys_side_master (
	input wire logic mclk,
	output logic [7:0] regAddr,
	output logic [7:0] regWrData,
	output logic regWrite,
	output logic regRead,
	input wire logic [7:0] regRdData
);
	import calib_dc_pkg::*;
	initial
	begin
		regAddr = 8'h00;
		regWrData = 8'h00;
		regWrite = 1'b0;
		regRead = 1'b0;
	end
	// ----------------------------------------------------------------
	// bus cycles
	// ----------------------------------------------------------------
	// one write strobe (none for the reserved offset), then an idle edge so strobes never toggle twice
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (a == CAL_OFS)
			v[4] = 1'b0;
		if (a == DC_OFS)
			v[3:2] = 2'h0;
		if (a == RSVD_OFS)
			return;
		regAddr <= a;
		regWrData <= v;
		regWrite <= 1'b1;
		@(posedge mclk);
		regWrite <= 1'b0;
		@(posedge mclk);
	endtask : wr
	// data is taken at the edge that closes the answer cycle
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge mclk);
		regRead <= 1'b0;
		@(posedge mclk);
		d = regRdData;
	endtask : rd
endmodule : sys_side_master

//--- tb/testbench.sv
// self-checking bench for the calibration and dc termination register bank
// assumes the checker is bound by its own file; run length shortened to 4
`timescale 1ns/10ps
module testbench;
	import calib_dc_pkg::*;
	typedef struct {logic [7:0] wr; logic [11:0] mv; logic [4:0] ma;} dc_row_t;
	typedef struct {logic [7:0] lc; logic [7:0] lv; logic zfd; logic [7:0] expLv; logic pulse;} m_row_t;
	localparam logic [15:0] RUN_LEN = 16'h0004; // short run keeps the bench quick
	logic mclk = 1'b0, rst = 1'b1, regWrite, regRead, autoCalRequest = 1'b0, calibRun;
	logic sampleValid = 1'b0, zeroForceDisable = 1'b0, currentLimitEnable, dcImpedanceSelect;
	logic polarityReversal;
	logic [7:0] regAddr, regWrData, regRdData, rdv, loopCurrentSample = 8'h00;
	logic [7:0] lineVoltageSample = 8'h00;
	logic [3:0] trimMeasured = 4'h0;
	logic [1:0] lineVoltageAdjust, minLoopCurrentSel;
	logic [11:0] terminationPinMv;
	logic [4:0] minLoopCurrentMa;
	int errCount = 0, checkCount = 0;
	dc_row_t dcTab [4] = '{'{8'h00, 12'hC1C, 5'h0A}, '{8'h51, 12'hC80, 5'h0C},
		'{8'hA2, 12'hD16, 5'h0E}, '{8'hF3, 12'hDAC, 5'h10}};
	// small magnitudes force zero; sign changes against the last nonzero value pulse
	m_row_t mTab [8] = '{'{8'h2A, 8'h30, 1'b0, 8'h30, 1'b0}, '{8'h00, 8'hD0, 1'b0, 8'hD0, 1'b1},
		'{8'h80, 8'h02, 1'b0, 8'h00, 1'b0}, '{8'h80, 8'h2F, 1'b0, 8'h2F, 1'b1},
		'{8'h11, 8'hFD, 1'b0, 8'h00, 1'b0}, '{8'h11, 8'hFD, 1'b1, 8'hFD, 1'b1},
		'{8'h11, 8'h04, 1'b0, 8'h04, 1'b1}, '{8'h11, 8'h00, 1'b0, 8'h00, 1'b0}};
	always #12.5 mclk = ~mclk;
	line_side_calib_dc_status_regs #(.CAL_RUN_CYCLES(RUN_LEN)) dut_u (.mclk(mclk), .rst(rst),
		.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .autoCalRequest(autoCalRequest), .trimMeasured(trimMeasured),
		.calibRun(calibRun), .sampleValid(sampleValid), .loopCurrentSample(loopCurrentSample),
		.lineVoltageSample(lineVoltageSample), .zeroForceDisable(zeroForceDisable),
		.lineVoltageAdjust(lineVoltageAdjust), .terminationPinMv(terminationPinMv),
		.minLoopCurrentSel(minLoopCurrentSel), .minLoopCurrentMa(minLoopCurrentMa),
		.currentLimitEnable(currentLimitEnable), .dcImpedanceSelect(dcImpedanceSelect),
		.polarityReversal(polarityReversal));
	sys_side_master master_u (.mclk(mclk), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData));
	// ----------------------------------------------------------------
	// checking and closing
	// ----------------------------------------------------------------
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		checkCount++;
		if (seen !== exp)
		begin
			errCount++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic close_out;
		if (errCount == 0 && checkCount > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out
	// bounded wait for the run to end, then realign to a rising edge
	task automatic wait_idle;
		int n;
		n = 0;
		while (calibRun !== 1'b0 && n < 50)
		begin
			@(negedge mclk);
			n++;
		end
		if (n == 50)
		begin
			errCount++;
			close_out();
		end
		else
			@(posedge mclk);
	endtask : wait_idle
	task automatic pulse_auto;
		autoCalRequest <= 1'b1;
		@(posedge mclk);
		autoCalRequest <= 1'b0;
		@(negedge mclk);
	endtask : pulse_auto
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		repeat (2) @(posedge mclk);
		foreach (dcTab[i])
		begin
			master_u.wr(DC_OFS, dcTab[i].wr);
			master_u.rd(DC_OFS, rdv);
			check(rdv, dcTab[i].wr);
			@(negedge mclk);
			check(terminationPinMv, dcTab[i].mv);
			check(minLoopCurrentMa, dcTab[i].ma);
			check({currentLimitEnable, dcImpedanceSelect}, dcTab[i].wr[1:0]);
			@(posedge mclk);
		end
		foreach (mTab[i])
		begin
			sampleValid <= 1'b1;
			loopCurrentSample <= mTab[i].lc;
			lineVoltageSample <= mTab[i].lv;
			zeroForceDisable <= mTab[i].zfd;
			@(posedge mclk);
			sampleValid <= 1'b0;
			@(negedge mclk);
			check(polarityReversal, mTab[i].pulse);
			@(posedge mclk);
			master_u.rd(LC_OFS, rdv);
			check(rdv, mTab[i].lc);
			master_u.rd(LV_OFS, rdv);
			check(rdv, mTab[i].expLv);
			master_u.rd(LV_OFS, rdv);
			check(rdv, mTab[i].expLv);
		end
		// manual run: flag and trim, then clear the start bit
		trimMeasured <= 4'hA;
		master_u.wr(CAL_OFS, 8'h40);
		master_u.rd(CAL_OFS, rdv);
		check(rdv, 8'hC0);
		wait_idle();
		master_u.rd(CAL_OFS, rdv);
		check(rdv, 8'h4A);
		// start bit cleared, trim written back
		master_u.wr(CAL_OFS, 8'h0A);
		// internal request blocked while disabled, then honoured
		master_u.wr(CAL_OFS, 8'h2A);
		pulse_auto();
		check(calibRun, 1'b0);
		@(posedge mclk);
		master_u.rd(CAL_OFS, rdv);
		check(rdv, 8'h2A);
		master_u.wr(CAL_OFS, 8'h0A);
		trimMeasured <= 4'h5;
		pulse_auto();
		check(calibRun, 1'b1);
		wait_idle();
		master_u.rd(CAL_OFS, rdv);
		check(rdv, 8'h05);
		master_u.rd(8'h20, rdv);
		check(rdv, 8'h00);
		// reset in mid-run clears everything
		pulse_auto();
		@(posedge mclk);
		rst <= 1'b1;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		@(negedge mclk);
		check(calibRun, 1'b0);
		check(terminationPinMv, 12'hC1C);
		@(posedge mclk);
		master_u.rd(CAL_OFS, rdv);
		check(rdv, 8'h00);
		master_u.rd(LV_OFS, rdv);
		check(rdv, 8'h00);
		close_out();
	end
endmodule : testbench
